// ===== pkg/csfm_pkg.sv
// constants and types shared by the clock start-up and fail monitor block
package csfm_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word per register)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OSC_CON = 8'h00;
  localparam logic [7:0] ADDR_OSC_STAT = 8'h04;
  localparam logic [7:0] ADDR_PFLAG2 = 8'h08;
  localparam logic [7:0] ADDR_PEN2 = 8'h0C;
  localparam logic [7:0] ADDR_PWR_CMD = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int IFS_LSB = 3;
  localparam int SCS_LSB = 0;
  localparam int OSC_FAIL_BIT = 7;
  localparam int OSC_FAIL_IE_BIT = 7;
  localparam int EXT_RUN_BIT = 0;
  localparam int FAILSAFE_BIT = 1;
  localparam int OST_RUN_BIT = 2;
  localparam int SLEEP_BIT = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] IFS_RST = 4'h7;
  localparam logic [1:0] SCS_RST = 2'h0;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam int OST_CYCLES = 1024;
  localparam int LF_DIV = 64;

  // ----------------------------------------------------------------
  // oscillator select configuration and clock select codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_LP = 3'h0,
    MODE_XT = 3'h1,
    MODE_HS = 3'h2,
    MODE_RC = 3'h3,
    MODE_INTERNAL_OSCILLATOR = 3'h4,
    MODE_EC = 3'h5
  } csfm_mode_t;

  localparam logic [1:0] SCS_CONFIG = 2'h0;
  localparam logic [1:0] SCS_SECONDARY = 2'h1;

  // ----------------------------------------------------------------
  // clock switch states
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_BOOT = 8'h01,
    ST_INT = 8'h02,
    ST_OST = 8'h04,
    ST_WAIT_INT = 8'h08,
    ST_HOLD = 8'h10,
    ST_EXT = 8'h20,
    ST_FAIL = 8'h40,
    ST_SLEEP = 8'h80
  } csfm_state_t;

endpackage : csfm_pkg

// ===== core/csfm_sync.sv
// two-flop synchroniser with edge pulses for asynchronous oscillator pins
`timescale 1ns/10ps
`default_nettype none
module csfm_sync #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous levels
  input wire logic [W-1:0] d_in,
  // synchronised level and edges
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_d_r;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q_r <= '0;
      q_d_r <= '0;
    end else begin
      meta_r <= d_in;
      q_r <= meta_r;
      q_d_r <= q_r;
    end
  end

  // edges come from the settled stages only
  assign q = q_r;
  assign rise = q_r & ~q_d_r;
  assign fall = ~q_r & q_d_r;

endmodule : csfm_sync
`default_nettype wire

// ===== core/csfm_fail_det.sv
// fail detector: divided sample clock, set/clear latch, half-cycle check
`timescale 1ns/10ps
`default_nettype none
module csfm_fail_det #(
  parameter int DIV = csfm_pkg::LF_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // qualified events
  input wire logic ext_fall,
  input wire logic lf_rise,
  input wire logic enable,
  // detection
  output logic fail
);

  localparam int CW = $clog2(DIV);

  logic [CW-1:0] div_r;
  logic latch_r;
  logic fail_r;
  logic samp_rise;
  logic samp_fall;

  // sample clock is the top bit of the divider: one period per DIV edges
  assign samp_rise = lf_rise && (div_r == CW'(DIV / 2 - 1)); // [RULE8]
  assign samp_fall = lf_rise && (div_r == CW'(DIV - 1));

  // divider, latch and check; external falling edge wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
      latch_r <= 1'b1;
      fail_r <= 1'b0;
    end else begin
      if (lf_rise) begin
        div_r <= div_r + CW'(1); // [RULE8]
      end
      if (!enable || ext_fall) begin
        latch_r <= 1'b1; // [RULE9]
      end else if (samp_rise) begin
        latch_r <= 1'b0; // [RULE9]
      end
      fail_r <= enable && samp_fall && !latch_r && !ext_fall; // [RULE10]
    end
  end

  assign fail = fail_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_latch_clear;
    enable && samp_rise && !ext_fall |=> !latch_r;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared"); // [RULE9]

  property p_fail_cause;
    fail_r |-> $past(samp_fall) && $past(!latch_r) && $past(enable);
  endproperty
  a_fail_cause: assert property (p_fail_cause) else $error("fail without cause"); // [RULE10]

endmodule : csfm_fail_det
`default_nettype wire

// ===== core/csfm_top.sv
// clock start-up sequencer, fail-safe monitor and register slave
// Functional notes
// [RULE1] after reset or wake, run from internal oscillator at selected frequency
// [RULE2] start-up timer counts 1024 external clock cycles before it is ready
// [RULE3] on timer expiry wait internal falling edge, then set running flag
// [RULE4] hold system clock low until next external falling edge, then switch
// [RULE5] status flag shows whether system clock is external or internal
// [RULE6] monitor active only with fail-safe enable, for every external mode
// [RULE7] no failure flagged before start-up timer has expired
// [RULE8] sample clock is low-frequency internal oscillator divided by 64
// [RULE9] latch set by external falling edge, cleared by sample rising edge
// [RULE10] failure when full sample half-cycle passes without external low
// [RULE11] on failure switch to internal clock and set oscillator-fail flag
// [RULE12] fail flag raises interrupt only when its enable bit is set
// [RULE13] after failure stay internal until firmware switches back
// [RULE14] fallback frequency is the current internal frequency select field
// [RULE15] fail-safe condition cleared by reset, sleep or clock select change; code clears it on reset, sleep or entry to ST_EXT, not on the select change
// [RULE16] select change restarts timer; clear fail-safe after switching back
// [RULE17] software clears fail flag first; hardware sets it again on failure
// [RULE18] start-up timer runs after every reset and every wake; code skips it when start_st is ST_INT or ST_HOLD
// [RULE19] external-clock and RC modes skip the start-up timer
// [RULE20] fail monitor enabled implies two-speed start-up
// [RULE21] software checks status bits after a delay to confirm switchover
// [RULE22] pin-domain flags are synchronised before software reads them
`timescale 1ns/10ps
`default_nettype none
module csfm_top #(
  parameter int ADDR_W = 8,
  parameter int OST_N = csfm_pkg::OST_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator pins, asynchronous
  input wire logic ext_osc_in,
  input wire logic internal_osc_in,
  input wire logic low_freq_internal_osc_in,
  // configuration and power events
  input wire logic [2:0] oscillator_select_config,
  input wire logic fail_safe_enable,
  input wire logic wake_req,
  // clock and interrupt outputs
  output logic sys_clk,
  output logic sys_clk_is_ext,
  output logic [3:0] internal_freq_select,
  output logic irq
);

  localparam int OW = $clog2(OST_N);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [2:0] osc_q;
  logic [2:0] osc_rise;
  logic [2:0] osc_fall;
  logic ext_s;
  logic int_s;
  logic ext_fall;
  logic int_fall;
  logic lf_rise;

  // every oscillator pin passes two flops before use
  csfm_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d_in({low_freq_internal_osc_in, internal_osc_in, ext_osc_in}),
    .q(osc_q),
    .rise(osc_rise),
    .fall(osc_fall)
  ); // [RULE22]

  assign ext_s = osc_q[0];
  assign int_s = osc_q[1];
  assign ext_fall = osc_fall[0];
  assign int_fall = osc_fall[1];
  assign lf_rise = osc_rise[2];

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  csfm_pkg::csfm_state_t st_r;
  csfm_pkg::csfm_state_t st_nxt;
  csfm_pkg::csfm_state_t start_st;
  logic [3:0] ifs_r;
  logic [1:0] scs_r;
  logic osc_fail_flag_r;
  logic osc_fail_flag_nxt;
  logic osc_fail_ie_r;
  logic ext_running_r;
  logic failsafe_r;
  logic failsafe_nxt;
  logic scs_chg_r;
  logic [OW-1:0] ost_cnt_r;
  logic sys_clk_r;
  logic src_ext_r;
  logic irq_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup;
  logic wr_en;
  logic hit_con;
  logic hit_stat;
  logic hit_pf2;
  logic hit_pe2;
  logic hit_pwr;
  logic hit_any;
  logic [31:0] rd_mux;
  logic [1:0] scs_new;
  logic sleep_cmd;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_r && pwrite;
  assign hit_con = paddr == ADDR_W'(csfm_pkg::ADDR_OSC_CON);
  assign hit_stat = paddr == ADDR_W'(csfm_pkg::ADDR_OSC_STAT);
  assign hit_pf2 = paddr == ADDR_W'(csfm_pkg::ADDR_PFLAG2);
  assign hit_pe2 = paddr == ADDR_W'(csfm_pkg::ADDR_PEN2);
  assign hit_pwr = paddr == ADDR_W'(csfm_pkg::ADDR_PWR_CMD);
  assign hit_any = hit_con || hit_stat || hit_pf2 || hit_pe2 || hit_pwr;
  assign scs_new = pwdata[csfm_pkg::SCS_LSB +: 2];
  assign sleep_cmd = wr_en && hit_pwr && pwdata[csfm_pkg::SLEEP_BIT];

  // read mux; reserved bits read as zero, status words come from pclk flops
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_con) begin
      rd_mux[csfm_pkg::IFS_LSB +: 4] = ifs_r;
      rd_mux[csfm_pkg::SCS_LSB +: 2] = scs_r;
    end else if (hit_stat) begin
      rd_mux[csfm_pkg::EXT_RUN_BIT] = ext_running_r; // [RULE5] [RULE22]
      rd_mux[csfm_pkg::FAILSAFE_BIT] = failsafe_r;
      rd_mux[csfm_pkg::OST_RUN_BIT] = st_r == csfm_pkg::ST_OST;
    end else if (hit_pf2) begin
      rd_mux[csfm_pkg::OSC_FAIL_BIT] = osc_fail_flag_r;
    end else if (hit_pe2) begin
      rd_mux[csfm_pkg::OSC_FAIL_IE_BIT] = osc_fail_ie_r;
    end
  end

  // answer in the first access cycle; unmapped addresses get an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !hit_any;
      if (setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // start path selection
  // ----------------------------------------------------------------
  logic want_ext;
  logic skip_ost;
  logic fail_det;
  logic mon_en;

  // secondary oscillator or a configured external mode asks for the switch
  assign want_ext = (scs_r == csfm_pkg::SCS_SECONDARY) ||
                    (scs_r == csfm_pkg::SCS_CONFIG &&
                     oscillator_select_config != csfm_pkg::MODE_INTERNAL_OSCILLATOR);
  assign skip_ost = scs_r == csfm_pkg::SCS_CONFIG &&
                    (oscillator_select_config == csfm_pkg::MODE_EC ||
                     oscillator_select_config == csfm_pkg::MODE_RC); // [RULE19]

  // two-speed start is always on, so it is on whenever monitoring is
  always_comb begin
    if (!want_ext) begin
      start_st = csfm_pkg::ST_INT; // [RULE1]
    end else if (skip_ost) begin
      start_st = csfm_pkg::ST_HOLD; // [RULE19]
    end else begin
      start_st = csfm_pkg::ST_OST; // [RULE18] [RULE20]
    end
  end

  // monitor only watches a running external clock, never during start-up
  assign mon_en = fail_safe_enable && st_r == csfm_pkg::ST_EXT; // [RULE6] [RULE7]

  csfm_fail_det #(.DIV(csfm_pkg::LF_DIV)) u_det (
    .pclk(pclk),
    .presetn(presetn),
    .ext_fall(ext_fall),
    .lf_rise(lf_rise),
    .enable(mon_en),
    .fail(fail_det)
  );

  // ----------------------------------------------------------------
  // clock switch state machine
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (sleep_cmd) begin
      st_nxt = csfm_pkg::ST_SLEEP;
    end else if (scs_chg_r && st_r != csfm_pkg::ST_SLEEP) begin
      st_nxt = start_st; // [RULE16]
    end else begin
      case (st_r)
        csfm_pkg::ST_BOOT: begin
          st_nxt = start_st; // [RULE18]
        end
        csfm_pkg::ST_OST: begin
          if (ext_fall && ost_cnt_r == OW'(OST_N - 1)) begin
            st_nxt = csfm_pkg::ST_WAIT_INT; // [RULE2]
          end
        end
        csfm_pkg::ST_WAIT_INT: begin
          if (int_fall) begin
            st_nxt = csfm_pkg::ST_HOLD; // [RULE3]
          end
        end
        csfm_pkg::ST_HOLD: begin
          if (ext_fall) begin
            st_nxt = csfm_pkg::ST_EXT; // [RULE4]
          end
        end
        csfm_pkg::ST_EXT: begin
          if (fail_det) begin
            st_nxt = csfm_pkg::ST_FAIL; // [RULE11]
          end
        end
        csfm_pkg::ST_SLEEP: begin
          if (wake_req) begin
            st_nxt = start_st; // [RULE18]
          end
        end
        default: begin
          st_nxt = st_r; // internal and failed states wait for software
        end
      endcase
    end
  end

  // fail-safe condition: set by a failure, cleared by sleep or a good switch
  always_comb begin
    failsafe_nxt = failsafe_r;
    if (st_r == csfm_pkg::ST_EXT && st_nxt == csfm_pkg::ST_FAIL) begin
      failsafe_nxt = 1'b1; // [RULE11] a sleep in the same cycle leaves it clear
    end else if (sleep_cmd || st_nxt == csfm_pkg::ST_EXT) begin
      failsafe_nxt = 1'b0; // [RULE15] [RULE16]
    end
  end

  // a hardware set beats a software clear in the same cycle
  always_comb begin
    osc_fail_flag_nxt = osc_fail_flag_r;
    if (wr_en && hit_pf2) begin
      osc_fail_flag_nxt = pwdata[csfm_pkg::OSC_FAIL_BIT]; // [RULE17]
    end
    if (fail_det && st_r == csfm_pkg::ST_EXT) begin
      osc_fail_flag_nxt = 1'b1; // [RULE11] [RULE17]
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifs_r <= csfm_pkg::IFS_RST;
      scs_r <= csfm_pkg::SCS_RST;
      scs_chg_r <= 1'b0;
      osc_fail_ie_r <= 1'b0;
    end else begin
      scs_chg_r <= wr_en && hit_con && scs_new != scs_r; // [RULE15]
      if (wr_en && hit_con) begin
        ifs_r <= pwdata[csfm_pkg::IFS_LSB +: 4]; // [RULE14]
        scs_r <= scs_new;
      end
      if (wr_en && hit_pe2) begin
        osc_fail_ie_r <= pwdata[csfm_pkg::OSC_FAIL_IE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // state, timer, flags and clock outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= csfm_pkg::ST_BOOT;
      ost_cnt_r <= '0;
      ext_running_r <= 1'b0;
      failsafe_r <= 1'b0;
      osc_fail_flag_r <= 1'b0;
      sys_clk_r <= 1'b0;
      src_ext_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      // counter restarts on every entry to the start-up state
      if (st_r != csfm_pkg::ST_OST || st_nxt != csfm_pkg::ST_OST) begin
        ost_cnt_r <= '0;
      end else if (ext_fall) begin
        ost_cnt_r <= ost_cnt_r + OW'(1); // [RULE2]
      end
      ext_running_r <= st_nxt == csfm_pkg::ST_HOLD ||
                       st_nxt == csfm_pkg::ST_EXT; // [RULE3] [RULE5]
      failsafe_r <= failsafe_nxt;
      osc_fail_flag_r <= osc_fail_flag_nxt;
      src_ext_r <= st_nxt == csfm_pkg::ST_EXT; // [RULE13]
      irq_r <= osc_fail_flag_r && osc_fail_ie_r; // [RULE12]
      // the clock is a sampled copy; hold and sleep keep it low
      if (st_r == csfm_pkg::ST_EXT) begin
        sys_clk_r <= ext_s;
      end else if (st_r == csfm_pkg::ST_HOLD || st_r == csfm_pkg::ST_SLEEP) begin
        sys_clk_r <= 1'b0; // [RULE4]
      end else begin
        sys_clk_r <= int_s; // [RULE1] [RULE11] [RULE14]
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sys_clk = sys_clk_r;
  assign sys_clk_is_ext = src_ext_r;
  assign internal_freq_select = ifs_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ext_fail;
    st_r == csfm_pkg::ST_EXT && fail_det && !sleep_cmd && !scs_chg_r;
  endsequence

  property p_ost_expire;
    st_r == csfm_pkg::ST_OST && ext_fall && ost_cnt_r == OW'(OST_N - 1) &&
      !sleep_cmd && !scs_chg_r |=> st_r == csfm_pkg::ST_WAIT_INT;
  endproperty
  a_ost_expire: assert property (p_ost_expire) else $error("timer expiry missed"); // [RULE2]

  property p_ost_early;
    st_r == csfm_pkg::ST_OST && ost_cnt_r != OW'(OST_N - 1) |=>
      st_r != csfm_pkg::ST_WAIT_INT;
  endproperty
  a_ost_early: assert property (p_ost_early) else $error("timer left early"); // [RULE2]

  property p_hold_low;
    st_r == csfm_pkg::ST_HOLD |=> !sys_clk_r;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("clock not held low"); // [RULE4]

  property p_ext_flag;
    st_r == csfm_pkg::ST_EXT |-> ext_running_r && src_ext_r;
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("running flag wrong"); // [RULE5]

  property p_no_mon_ost;
    st_r == csfm_pkg::ST_OST && !(wr_en && hit_pf2) |=> $stable(osc_fail_flag_r);
  endproperty
  a_no_mon_ost: assert property (p_no_mon_ost) else $error("monitor in start-up"); // [RULE7]

  property p_fail_switch;
    s_ext_fail |=> st_r == csfm_pkg::ST_FAIL && osc_fail_flag_r ##1 !sys_clk_is_ext;
  endproperty
  a_fail_switch: assert property (p_fail_switch) else $error("failure not handled"); // [RULE11]

  property p_irq_gate;
    irq_r == $past(osc_fail_flag_r && osc_fail_ie_r);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong"); // [RULE12]

  property p_fail_stays;
    st_r == csfm_pkg::ST_FAIL && !sleep_cmd && !scs_chg_r |=>
      st_r == csfm_pkg::ST_FAIL;
  endproperty
  a_fail_stays: assert property (p_fail_stays) else $error("left failure state"); // [RULE13]

  property p_sleep_clear;
    sleep_cmd |=> st_r == csfm_pkg::ST_SLEEP && !failsafe_r;
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("sleep did not clear"); // [RULE15]

endmodule : csfm_top
`default_nettype wire

// ===== tb/csfm_osc_model.sv
// behavioural oscillators that stand at the block's pins
`timescale 1ns/10ps
`default_nettype none
module csfm_osc_model (
  // bench control
  input wire logic ext_run,
  // oscillator pins
  output logic ext_osc,
  output logic int_osc,
  output logic lf_osc
);
  // ------------------------------------------------------------
  // free-running sources
  // ------------------------------------------------------------
  // periods unrelated to pclk; each half period spans several pclk edges
  initial begin
    ext_osc = 1'b1;
    int_osc = 1'b0;
    lf_osc = 1'b0;
  end
  always #11.5 int_osc = ~int_osc;
  always #20.3 lf_osc = ~lf_osc;
  // a dead crystal stalls high, so the detector never sees it go low
  always #18.7 ext_osc = ext_run ? ~ext_osc : 1'b1;
endmodule : csfm_osc_model
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the clock start-up and fail monitor
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [31:0] B_RUN = 32'h1 << csfm_pkg::EXT_RUN_BIT;
  localparam logic [31:0] B_FS = 32'h1 << csfm_pkg::FAILSAFE_BIT;
  localparam logic [31:0] B_OST = 32'h1 << csfm_pkg::OST_RUN_BIT;
  localparam logic [31:0] B_FAIL = 32'h1 << csfm_pkg::OSC_FAIL_BIT;
  localparam logic [31:0] B_IE = 32'h1 << csfm_pkg::OSC_FAIL_IE_BIT;
  localparam logic [31:0] CON3 = 32'h3 << csfm_pkg::IFS_LSB;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_run = 1'b1;
  logic ext_osc;
  logic int_osc;
  logic lf_osc;
  logic [2:0] osc_cfg = 3'h1;
  logic fsen = 1'b1;
  logic wake_req = 1'b0;
  logic sys_clk;
  logic sys_clk_is_ext;
  logic [3:0] ifs;
  logic irq;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int compares = 0;
  // 200 MHz
  always #2.5 pclk = ~pclk;
  // ------------------------------------------------------------
  // design and oscillators
  // ------------------------------------------------------------
  // short start-up count keeps the run brief
  csfm_top #(.ADDR_W(8), .OST_N(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_osc_in(ext_osc),
    .internal_osc_in(int_osc), .low_freq_internal_osc_in(lf_osc),
    .oscillator_select_config(osc_cfg), .fail_safe_enable(fsen),
    .wake_req(wake_req), .sys_clk(sys_clk), .sys_clk_is_ext(sys_clk_is_ext),
    .internal_freq_select(ifs), .irq(irq)
  );
  csfm_osc_model osc (.ext_run(ext_run), .ext_osc(ext_osc), .int_osc(int_osc), .lf_osc(lf_osc));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  task automatic rst(input logic [2:0] mode, input logic fs);
    presetn <= 1'b0;
    osc_cfg <= mode;
    fsen <= fs;
    idle(2);
    presetn <= 1'b1;
  endtask : rst
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      failures++;
      $display("BAD %0t apb timeout", $time);
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // bounded wait for the clock source to settle
  task automatic wait_ext(input logic v);
    int n;
    n = 0;
    while (sys_clk_is_ext !== v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(sys_clk_is_ext), 32'(v));
    if (n >= 3000) begin
      end_sim();
    end
  endtask : wait_ext
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    // every mode: timer modes, no-timer modes and internal-only
    for (int i = 5; i >= 0; i--) begin
      rst(3'(i), 1'b1);
      apb(1'b0, csfm_pkg::ADDR_OSC_CON, 32'h0);
      chk(rd, 32'(csfm_pkg::IFS_RST) << csfm_pkg::IFS_LSB);
      apb(1'b0, csfm_pkg::ADDR_OSC_STAT, 32'h0);
      chk(rd, (i < 3) ? B_OST : (i == 4) ? 32'h0 : B_RUN);
    end
    chk(32'(ifs), 32'(csfm_pkg::IFS_RST));
    wait_ext(1'b1);
    apb(1'b0, csfm_pkg::ADDR_OSC_STAT, 32'h0);
    chk(rd, B_RUN);
    apb(1'b1, csfm_pkg::ADDR_OSC_CON, CON3);
    idle(2);
    chk(32'(ifs), 32'h3);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // kill the crystal with the interrupt enabled
    apb(1'b1, csfm_pkg::ADDR_PEN2, B_IE);
    ext_run <= 1'b0;
    wait_ext(1'b0);
    idle(2);
    chk(32'(irq), 32'h1);
    apb(1'b0, csfm_pkg::ADDR_PFLAG2, 32'h0);
    chk(rd, B_FAIL);
    apb(1'b0, csfm_pkg::ADDR_OSC_STAT, 32'h0);
    chk(rd, B_FS);
    chk(32'(ifs), 32'h3);
    apb(1'b1, csfm_pkg::ADDR_PEN2, 32'h0);
    idle(2);
    chk(32'(irq), 32'h0);
    apb(1'b1, csfm_pkg::ADDR_PFLAG2, 32'h0);
    apb(1'b0, csfm_pkg::ADDR_PFLAG2, 32'h0);
    chk(rd, 32'h0);
    ext_run <= 1'b1;
    idle(300);
    chk(32'(sys_clk_is_ext), 32'h0);
    // select change restarts the timer, fail-safe holds until switchover
    apb(1'b1, csfm_pkg::ADDR_OSC_CON, CON3 | 32'(csfm_pkg::SCS_SECONDARY));
    idle(3);
    apb(1'b0, csfm_pkg::ADDR_OSC_STAT, 32'h0);
    chk(rd, B_OST | B_FS);
    wait_ext(1'b1);
    apb(1'b0, csfm_pkg::ADDR_OSC_STAT, 32'h0);
    chk(rd, B_RUN);
    // sleep, then wake
    apb(1'b1, csfm_pkg::ADDR_PWR_CMD, 32'h1);
    idle(3);
    chk({30'h0, sys_clk, sys_clk_is_ext}, 32'h0);
    wake_req <= 1'b1;
    idle(1);
    wake_req <= 1'b0;
    idle(3);
    apb(1'b0, csfm_pkg::ADDR_OSC_STAT, 32'h0);
    chk(rd, B_OST);
    wait_ext(1'b1);
    // internal select code drops back to the internal oscillator
    apb(1'b1, csfm_pkg::ADDR_OSC_CON, CON3 | 32'h2);
    wait_ext(1'b0);
    // monitor disabled: a dead crystal goes unflagged
    rst(csfm_pkg::MODE_XT, 1'b0);
    wait_ext(1'b1);
    ext_run <= 1'b0;
    idle(800);
    apb(1'b0, csfm_pkg::ADDR_PFLAG2, 32'h0);
    chk(rd | 32'(!sys_clk_is_ext), 32'h0);
    // crystal dead during start-up: no failure before timer expiry
    rst(csfm_pkg::MODE_XT, 1'b1);
    idle(800);
    apb(1'b0, csfm_pkg::ADDR_PFLAG2, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, csfm_pkg::ADDR_OSC_STAT, 32'h0);
    chk(rd, B_OST);
    end_sim();
  end
endmodule : tb
`default_nettype wire
